// ===== pkg/pmc_defines.vh
// register offsets, field positions, reset values and timing for pmc regs
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// register offsets on the serial-interface register port
`define PMC_OFS_CTRL2 8'h05
`define PMC_OFS_CORE 8'h06
`define PMC_OFS_SLEW 8'h07
`define PMC_OFS_LINREG 8'h08

// field positions
`define PMC_LAUNCH_BIT 7
`define PMC_CORE_MSB 4
`define PMC_SLEW_MSB 2
`define PMC_LINA_LSB 0
`define PMC_LINA_MSB 2
`define PMC_LINB_LSB 4
`define PMC_LINB_MSB 6

// reset values and the immediate slew code
`define PMC_CORE_DEF_LOW 5'h14
`define PMC_CORE_DEF_HIGH 5'h1E
`define PMC_SLEW_RST 3'h6
`define PMC_SLEW_IMMEDIATE 3'h7
`define PMC_LINREG_RST 3'h0

// timing: one 25 mV step at the slowest rate of 0.15 mV/us, in ns
`define PMC_STEP_SLOW_NS 166667
`define PMC_CLK_PERIOD_NS 10
// whole cycles of the slow step at the clock period above, sized for the timer
`define PMC_STEP_SLOW_CYCLES 20'd16666
`define PMC_TMR_W 20

`endif

// ===== verilog/pmc_step_timer.v
// step interval timer for the core voltage ramp
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_step_timer #(
  parameter [`PMC_TMR_W-1:0] STEP_SLOW_CYCLES = `PMC_STEP_SLOW_CYCLES
) (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // control
  input wire run_i,
  input wire [2:0] rate_i,
  // one-cycle step strobe
  output reg tick_o
);

  reg [`PMC_TMR_W-1:0] cnt_q;
  wire [`PMC_TMR_W-1:0] interval;

  // rate doubles per code, so the interval halves per code
  assign interval = STEP_SLOW_CYCLES >> rate_i;

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= {`PMC_TMR_W{1'b0}};
      tick_o <= 1'b0;
    end else if (!run_i) begin
      // idle reload so every ramp starts a full interval
      cnt_q <= interval;
      tick_o <= 1'b0;
    end else if (cnt_q <= {{(`PMC_TMR_W-1){1'b0}}, 1'b1}) begin
      cnt_q <= interval;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q - {{(`PMC_TMR_W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end

endmodule

// ===== verilog/pmc_regs.v
// core voltage scaling and linear regulator voltage control registers
`timescale 1ns/1ps
`include "pmc_defines.vh"

module pmc_regs #(
  parameter [`PMC_TMR_W-1:0] STEP_SLOW_CYCLES = `PMC_STEP_SLOW_CYCLES,
  // regulator defaults per strap pair {b,a}, each entry {b[2:0], a[2:0]}
  parameter [5:0] LINREG_DEF_00 = 6'h00,
  parameter [5:0] LINREG_DEF_01 = 6'h09,
  parameter [5:0] LINREG_DEF_10 = 6'h12,
  parameter [5:0] LINREG_DEF_11 = 6'h3F
) (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // register port from the serial interface
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  output reg [7:0] reg_rdata_o,
  // supervisor events
  input wire undervoltage_lockout_i,
  input wire conv_a_enabled_i,
  input wire conv_c_enabled_i,
  input wire warm_reset_input_n_i,
  input wire power_on_reset_i,
  input wire backup_low_i,
  // strap pins
  input wire core_default_strap_i,
  input wire linreg_default_strap_a_i,
  input wire linreg_default_strap_b_i,
  // controls to the analog side
  output reg [4:0] core_out_code_o,
  output reg [2:0] ramp_rate_o,
  output reg [2:0] linreg_a_code_o,
  output reg [2:0] linreg_b_code_o,
  output reg ramp_busy_o
);

  reg [4:0] core_code_q;
  reg [4:0] core_code_d;
  reg [2:0] slew_q;
  reg [2:0] slew_d;
  reg [2:0] lina_q;
  reg [2:0] lina_d;
  reg [2:0] linb_q;
  reg [2:0] linb_d;
  reg launch_q;
  reg launch_d;
  reg [4:0] out_q;
  reg [4:0] out_d;
  reg init_q;
  reg [5:0] lin_def;
  reg [7:0] rdata_d;

  wire wr_ctrl2;
  wire wr_core;
  wire wr_slew;
  wire wr_linreg;
  wire lockout;
  wire core_rst;
  wire [4:0] core_def;
  wire launch_set;
  wire at_target;
  wire timer_run;
  wire tick;

  assign wr_ctrl2 = reg_wr_i && (reg_addr_i == `PMC_OFS_CTRL2);
  assign wr_core = reg_wr_i && (reg_addr_i == `PMC_OFS_CORE);
  assign wr_slew = reg_wr_i && (reg_addr_i == `PMC_OFS_SLEW);
  assign wr_linreg = reg_wr_i && (reg_addr_i == `PMC_OFS_LINREG);

  // init_q stands in for a lockout on the first cycle after reset, so
  // straps are caught by a clocked process, never by the async reset
  assign lockout = undervoltage_lockout_i || init_q;

  assign core_rst = lockout
                 || (!conv_a_enabled_i && !conv_c_enabled_i)
                 || !warm_reset_input_n_i
                 || power_on_reset_i
                 || backup_low_i;

  assign core_def = core_default_strap_i ? `PMC_CORE_DEF_HIGH :
                    `PMC_CORE_DEF_LOW;

  assign launch_set = wr_ctrl2 && reg_wdata_i[`PMC_LAUNCH_BIT];
  assign at_target = (out_q == core_code_q);
  assign timer_run = launch_q && !at_target && !core_rst;

  pmc_step_timer #(
    .STEP_SLOW_CYCLES(STEP_SLOW_CYCLES)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .run_i(timer_run),
    .rate_i(slew_q),
    .tick_o(tick)
  );

  // strap decode for regulator defaults
  always @* begin
    case ({linreg_default_strap_b_i, linreg_default_strap_a_i})
      2'b00: lin_def = LINREG_DEF_00;
      2'b01: lin_def = LINREG_DEF_01;
      2'b10: lin_def = LINREG_DEF_10;
      default: lin_def = LINREG_DEF_11;
    endcase
  end

  // register file next state
  always @* begin
    core_code_d = core_code_q;
    slew_d = slew_q;
    lina_d = lina_q;
    linb_d = linb_q;
    if (core_rst) begin
      core_code_d = core_def;
    end else if (wr_core) begin
      core_code_d = reg_wdata_i[`PMC_CORE_MSB:0];
    end
    if (lockout) begin
      slew_d = `PMC_SLEW_RST;
      lina_d = lin_def[2:0];
      linb_d = lin_def[5:3];
    end else begin
      if (wr_slew) begin
        // upper bits are not stored and read back as zero
        slew_d = reg_wdata_i[`PMC_SLEW_MSB:0];
      end
      if (wr_linreg) begin
        lina_d = reg_wdata_i[`PMC_LINA_MSB:`PMC_LINA_LSB];
        linb_d = reg_wdata_i[`PMC_LINB_MSB:`PMC_LINB_LSB];
      end
    end
  end

  // ramp: output code walks toward the programmed code
  always @* begin
    out_d = out_q;
    launch_d = launch_q;
    if (core_rst) begin
      // a reset event also aborts any ramp in flight
      out_d = core_def;
      launch_d = 1'b0;
    end else if (launch_q) begin
      if (at_target) begin
        // done: self-clear, but a launch written now wins
        launch_d = launch_set;
      end else if (slew_q == `PMC_SLEW_IMMEDIATE) begin
        out_d = core_code_q;
      end else if (tick) begin
        if (out_q < core_code_q) begin
          out_d = out_q + 5'h01;
        end else begin
          out_d = out_q - 5'h01;
        end
      end
    end else if (launch_set) begin
      launch_d = 1'b1;
    end
  end

  // read mux, unmapped offsets read zero
  always @* begin
    case (reg_addr_i)
      `PMC_OFS_CTRL2: rdata_d = {launch_q, 7'h00};
      `PMC_OFS_CORE: rdata_d = {3'h0, core_code_q};
      `PMC_OFS_SLEW: rdata_d = {5'h00, slew_q};
      `PMC_OFS_LINREG: rdata_d = {1'b0, linb_q, 1'b0, lina_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      init_q <= 1'b1;
      core_code_q <= `PMC_CORE_DEF_LOW;
      slew_q <= `PMC_SLEW_RST;
      lina_q <= `PMC_LINREG_RST;
      linb_q <= `PMC_LINREG_RST;
      launch_q <= 1'b0;
      out_q <= `PMC_CORE_DEF_LOW;
    end else begin
      init_q <= 1'b0;
      core_code_q <= core_code_d;
      slew_q <= slew_d;
      lina_q <= lina_d;
      linb_q <= linb_d;
      launch_q <= launch_d;
      out_q <= out_d;
    end
  end

  // outputs straight from flops, one cycle behind the state
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
      core_out_code_o <= `PMC_CORE_DEF_LOW;
      ramp_rate_o <= `PMC_SLEW_RST;
      linreg_a_code_o <= `PMC_LINREG_RST;
      linreg_b_code_o <= `PMC_LINREG_RST;
      ramp_busy_o <= 1'b0;
    end else begin
      reg_rdata_o <= rdata_d;
      core_out_code_o <= out_q;
      ramp_rate_o <= slew_q;
      linreg_a_code_o <= lina_q;
      linreg_b_code_o <= linb_q;
      ramp_busy_o <= launch_q;
    end
  end

endmodule

// ===== test/pmc_regs_assertions.sv
// concurrent checks on the pmc_regs ports
`timescale 1ns/1ps
module pmc_regs_chk (
  // clock and reset
  input wire logic core_clk_i, reset_i,
  // register port
  input wire logic [7:0] reg_addr_i, reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_rdata_o,
  // events and straps
  input wire logic undervoltage_lockout_i, conv_a_enabled_i,
  input wire logic conv_c_enabled_i, warm_reset_input_n_i,
  input wire logic power_on_reset_i, backup_low_i, core_default_strap_i,
  input wire logic linreg_default_strap_a_i, linreg_default_strap_b_i,
  // analog controls
  input wire logic [4:0] core_out_code_o,
  input wire logic [2:0] ramp_rate_o, linreg_a_code_o, linreg_b_code_o,
  input wire logic ramp_busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  wire uv = undervoltage_lockout_i;
  wire ev = uv | ~(conv_a_enabled_i | conv_c_enabled_i) | power_on_reset_i
    | ~warm_reset_input_n_i | backup_low_i;
  wire [1:0] st = {linreg_default_strap_b_i, linreg_default_strap_a_i};
  // defaults must track the design's parameter defaults
  wire [5:0] ldef = st == 2'h0 ? 6'h00 : st == 2'h1 ? 6'h09 :
    st == 2'h2 ? 6'h12 : 6'h3F;
  wire [4:0] cdef = core_default_strap_i ? 5'h1E : 5'h14;
  slew_lockout_a: assert property (uv [*2] |=> ramp_rate_o == 3'h6)
    else $error("slew not at default after lockout");
  linreg_strap_a: assert property (uv [*2] |=>
    {linreg_b_code_o, linreg_a_code_o} == ldef)
    else $error("regulator codes not strap defaults");
  core_default_a: assert property (ev [*2] |=>
    core_out_code_o == cdef && !ramp_busy_o)
    else $error("core code not at default on reset event");
  ramp_step_a: assert property (
    (!reset_i && !ev && ramp_rate_o != 3'h7) [*3] |=>
    core_out_code_o == $past(core_out_code_o) ||
    core_out_code_o == $past(core_out_code_o) + 5'h01 ||
    core_out_code_o == $past(core_out_code_o) - 5'h01)
    else $error("core code moved more than one step");
  slew_rsvd_a: assert property (!reset_i && reg_addr_i == 8'h07 |=>
    reg_rdata_o == {5'h00, ramp_rate_o})
    else $error("slew readback differs from rate output");
  unmapped_rd_a: assert property (reg_addr_i > 8'h08 |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  slew_write_a: assert property (
    reg_wr_i && reg_addr_i == 8'h07 && !uv |=>
    ##1 ramp_rate_o == $past(reg_wdata_i[2:0], 2))
    else $error("rate output not written value");
  linreg_write_a: assert property (
    reg_wr_i && reg_addr_i == 8'h08 && !uv
    |=> ##1 linreg_b_code_o == $past(reg_wdata_i[6:4], 2) &&
    linreg_a_code_o == $past(reg_wdata_i[2:0], 2))
    else $error("regulator codes not written value");
  launch_busy_a: assert property (
    reg_wr_i && reg_addr_i == 8'h05 && reg_wdata_i[7] && !ev |=>
    ##1 ramp_busy_o)
    else $error("launch did not raise busy");
endmodule
bind pmc_regs pmc_regs_chk i_pmc_regs_chk (.*);

// ===== test/tb_top.sv
// self-checking bench for pmc_regs
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, wr = 0, uv = 0, ca = 1, cc = 1, wn = 1, por = 0;
  logic bk = 0, sa = 1, sb = 0, vld = 0, busy, cs = 1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, lf = 8'h59, obs;
  logic [4:0] core;
  logic [2:0] rate, la, lb;
  logic [9:0] q[$];
  string nm[4] = '{"rdata", "core_out", "ramp_rate", "linreg"};
  int num_errors = 0, checked = 0, cyc = 0;
  pmc_regs #(.STEP_SLOW_CYCLES(20'd64)) i_pmc_regs (.core_clk_i(clk),
    .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rdata_o(rdata), .undervoltage_lockout_i(uv),
    .conv_a_enabled_i(ca), .conv_c_enabled_i(cc),
    .warm_reset_input_n_i(wn), .power_on_reset_i(por),
    .backup_low_i(bk), .core_default_strap_i(cs),
    .linreg_default_strap_a_i(sa), .linreg_default_strap_b_i(sb),
    .core_out_code_o(core), .ramp_rate_o(rate), .linreg_a_code_o(la),
    .linreg_b_code_o(lb), .ramp_busy_o(busy));
  initial forever #5 clk = ~clk;
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic expv(input logic [1:0] s, input logic [7:0] v);
    @(posedge clk) vld <= 1;
    q.push_back({s, v});
    @(posedge clk) vld <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk) addr <= a;
    expv(0, e);
  endtask
  task automatic wrt(input logic [7:0] a, d);
    @(posedge clk) begin
      addr <= a;
      wd <= d;
      wr <= 1;
    end
    @(posedge clk) wr <= 0;
  endtask
  // result seen away from the launching edge
  always @(negedge clk) if (vld && q.size() > 0) begin
    case (q[0][9:8])
      2'd0: obs = rdata;
      2'd1: obs = {3'h0, core};
      2'd2: obs = {5'h0, rate};
      default: obs = {1'b0, lb, 1'b0, la};
    endcase
    chk(nm[q[0][9:8]], q[0][7:0], obs);
    void'(q.pop_front());
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    rd(8'h07, 8'h06);
    rd(8'h08, 8'h11);
    rd(8'h06, 8'h1E);
    rd(8'h05, 8'h00);
    rd(8'h3C, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      wrt(8'h07, {lf[7:3], i[2:0]});
      expv(2, i[2:0]);
      rd(8'h07, i[2:0]);
      wrt(8'h08, ~lf);
      rd(8'h08, ~lf & 8'h77);
      expv(3, ~lf & 8'h77);
    end
    sb <= 1;
    @(posedge clk) uv <= 1;
    wrt(8'h07, 8'h01);
    @(posedge clk) uv <= 0;
    rd(8'h08, 8'h77);
    rd(8'h07, 8'h06);
    expv(1, 8'h1E);
    wrt(8'h06, 8'h1C);
    wrt(8'h07, 8'h00);
    wrt(8'h05, 8'h80);
    expv(1, 8'h1E);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
    expv(1, 8'h1C);
    rd(8'h05, 8'h00);
    wrt(8'h06, 8'h1F);
    wrt(8'h07, 8'h07);
    wrt(8'h05, 8'h80);
    repeat (3) @(posedge clk);
    expv(1, 8'h1F);
    for (int k = 0; k < 4; k++) begin
      wrt(8'h06, 8'hEA);
      rd(8'h06, 8'h0A);
      {wn, por, bk, ca, cc} <= {k != 0, k == 1, k == 2, {2{k != 3}}};
      // last event also flips the core strap, so the low default is seen
      cs <= k != 3;
      repeat (3) @(posedge clk);
      {wn, por, bk, ca, cc} <= 5'b10011;
      rd(8'h06, k == 3 ? 8'h14 : 8'h1E);
      expv(1, k == 3 ? 8'h14 : 8'h1E);
    end
    end_sim();
  end
endmodule
